// File: verilog/rtsc_pkg.sv
// rtsc_pkg: constants shared by the receive tuning and synthesizer control register bank
package rtsc_pkg;

    // ----------------------------------------------------------------
    // register addresses on the configuration port
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] ADDR_RX_FRONTEND_TUNING = 8'h17;
    localparam logic [7:0] ADDR_SYNTH_CONTROL_STATUS = 8'h18;

    // ----------------------------------------------------------------
    // receive tuning register fields
    // ----------------------------------------------------------------
    localparam int RX_RSVD_HI = 15;
    localparam int RX_RSVD_LO = 14;
    localparam int RX_STORED_W = 14;
    localparam int RX_BPF_LOW_BIT = 13;
    localparam int RX_BPF_MID_BIT = 12;
    localparam int RX_AMP_LOWGAIN_LOW_BIT = 11;
    localparam int RX_AMP_LOWGAIN_MED_BIT = 10;
    localparam int RX_MIX_HGM_HIGH_BIT = 9;
    localparam int RX_MIX_HGM_MED_BIT = 8;
    localparam int RX_VARACTOR_LO = 6;
    localparam int RX_MIX_TAIL_LO = 4;
    localparam int RX_MIX_VCM_LO = 2;
    localparam int RX_MIX_CUR_LO = 0;
    localparam logic [13:0] RX_RESET = 14'h0a56;

    // ----------------------------------------------------------------
    // synthesizer control and status fields
    // ----------------------------------------------------------------
    localparam int SY_THR_LO = 14;
    localparam int SY_CAL_DONE_BIT = 13;
    localparam int SY_CAL_ACTIVE_BIT = 12;
    localparam int SY_WIN_LEN_BIT = 11;
    localparam int SY_LOCK_BIT = 10;
    localparam int CHAN_W = 10;
    localparam logic [1:0] THR_RESET = 2'h1;
    localparam logic WIN_LEN_RESET = 1'b0;
    localparam logic [9:0] CHAN_RESET = 10'h165;

    // ----------------------------------------------------------------
    // frequency plan and lock detector sizing
    // ----------------------------------------------------------------
    localparam int CHANNEL_WORD_W = 12;
    localparam logic [11:0] CARRIER_BASE_MHZ = 12'h800;
    localparam logic [11:0] RX_LO_OFFSET_MHZ = 12'h002;
    localparam int LOCK_CNT_W = 10;
    localparam logic [9:0] LOCK_BASE_COUNT = 10'h040;
    localparam logic [2:0] WIN_SHORT_PERIODS = 3'h2;
    localparam logic [2:0] WIN_LONG_PERIODS = 3'h4;

endpackage

// File: verilog/rtsc_lock_if.sv
// rtsc_lock_if: carrier between the register bank and its lock detector
`timescale 1ns/1ps
`default_nettype none
interface rtsc_lock_if;
    logic enable;          // synthesizer powered
    logic refTick;         // one reference clock period elapsed
    logic windowOk;        // window of that period succeeded
    logic [1:0] threshold; // lock count code
    logic locked;          // lock status
    logic [9:0] runCount;  // current unbroken run

    modport ctrl (output enable, output refTick, output windowOk, output threshold,
                  input locked, input runCount);
    modport det (input enable, input refTick, input windowOk, input threshold,
                 output locked, output runCount);
endinterface
`default_nettype wire

// File: verilog/rtsc_lock_detect.sv
// rtsc_lock_detect: consecutive successful window counter giving lock status
`timescale 1ns/1ps
`default_nettype none
module rtsc_lock_detect (
    // clock and synchronised reset
    input wire logic clk,
    input wire logic rstSync_n,
    // link to the register bank
    rtsc_lock_if.det lk
);

    // ----------------------------------------------------------------
    // threshold decode
    // ----------------------------------------------------------------
    // code 0..3 maps to 64,128,256,512 periods
    function automatic logic [9:0] thresholdCount(input logic [1:0] code);
        thresholdCount = rtsc_pkg::LOCK_BASE_COUNT << code;
    endfunction

    logic [9:0] count;      // unbroken run of good periods
    logic locked;           // lock reached
    logic [9:0] next_count;
    logic next_locked;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // saturate the count at the threshold so it never wraps while locked
    always_comb begin
        next_count = count;
        next_locked = locked;
        if (!lk.enable) begin
            // powered down: forget the run
            next_count = '0;
            next_locked = 1'b0;
        end else if (lk.refTick) begin
            if (!lk.windowOk) begin
                // failed window restarts the run
                next_count = '0;
                next_locked = 1'b0;
            end else if (count + 10'h001 >= thresholdCount(lk.threshold)) begin
                // run long enough
                next_count = thresholdCount(lk.threshold);
                next_locked = 1'b1;
            end else begin
                next_count = count + 10'h001;
            end
        end
    end

    // registers only
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            count <= '0;
            locked <= 1'b0;
        end else begin
            count <= next_count;
            locked <= next_locked;
        end
    end

    assign lk.locked = locked;
    assign lk.runCount = count;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_fail_restarts_run: assert property (@(posedge clk) disable iff (!rstSync_n)
        lk.refTick && !lk.windowOk |=> count == 10'h000 && !locked)
        else $error("failed window did not restart the run");
    chk_lock_at_threshold: assert property (@(posedge clk) disable iff (!rstSync_n)
        $rose(locked) |-> $past(count) + 10'h001 >= thresholdCount($past(lk.threshold))
                          && $past(lk.windowOk) && $past(lk.refTick))
        else $error("lock reported before the threshold run");

endmodule // rtsc_lock_detect
`default_nettype wire

// File: verilog/rtsc_regs.sv
// rtsc_regs: receive front-end tuning and synthesizer control/status register bank
// Function
// - amplifier lowgain selects reset to 1 and 0
// - four 2-bit tuning fields drive the front end
// - lock threshold code selects 64 to 512 periods
// - lock flag reads current synthesizer lock
// - calibration done set, cleared on synth turn-on
// - calibration active flag follows running calibration
// - window width bit selects 2 or 4 periods
// - channel word resets 357, carrier 2048 plus word
// - oscillator at carrier in transmit, minus 2 receive
`timescale 1ns/1ps
`default_nettype none
module rtsc_regs (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // configuration port, decoded on the device clock
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [15:0] regWrData,
    input wire logic regRdEn,
    output logic [15:0] regRdData,
    output logic regRdValid,
    // synthesizer status from its controller
    input wire logic synthOn,
    input wire logic txMode,
    input wire logic refTick,
    input wire logic windowOk,
    input wire logic calActive,
    // receive front-end settings
    output logic bandpassLowBiasSel,
    output logic bandpassMidBiasSel,
    output logic ampLowgainInAgcLow,
    output logic ampLowgainInAgcMedium,
    output logic mixerHighgainInAgcHigh,
    output logic mixerHighgainInAgcMedium,
    output logic [1:0] ampVaractorSel,
    output logic [1:0] mixerOutputCurrent,
    output logic [1:0] mixerCommonModeLevel,
    output logic [1:0] mixerCoreCurrent,
    // synthesizer settings
    output logic [2:0] windowPeriods,
    output logic [11:0] loFreqMhz,
    output logic synthLocked
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rstPipe; // two-stage release of the asynchronous reset
    logic rstSync_n;     // reset copy used everywhere else

    // assert at once, release after two edges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    // only the second stage is read, so release never lands mid-cycle
    assign rstSync_n = rstPipe[1];

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // any other address hits neither select and reads zero
    logic selRx;    // tuning register addressed
    logic selSynth; // synthesizer register addressed
    assign selRx = regAddr == rtsc_pkg::ADDR_RX_FRONTEND_TUNING;
    assign selSynth = regAddr == rtsc_pkg::ADDR_SYNTH_CONTROL_STATUS;

    // ----------------------------------------------------------------
    // stored settings
    // ----------------------------------------------------------------
    logic [13:0] rxTuning;  // tuning bits 13:0, the reserved pair is not kept
    logic [1:0] lockThr;    // lock count code
    logic winLen;           // window width select
    logic [9:0] chanWord;   // channel word
    logic [13:0] next_rxTuning;
    logic [1:0] next_lockThr;
    logic next_winLen;
    logic [9:0] next_chanWord;

    // a write takes effect at the next edge
    // write decode; status bits in the data word are simply dropped
    always_comb begin
        next_rxTuning = rxTuning;
        next_lockThr = lockThr;
        next_winLen = winLen;
        next_chanWord = chanWord;
        if (regWrEn && selRx) begin
            // reserved top bits are write-only and not stored
            next_rxTuning = regWrData[13:0];
        end
        if (regWrEn && selSynth) begin
            next_lockThr = regWrData[rtsc_pkg::SY_THR_LO +: 2];
            next_winLen = regWrData[rtsc_pkg::SY_WIN_LEN_BIT];
            next_chanWord = regWrData[rtsc_pkg::CHAN_W-1:0];
        end
    end

    // settings registers
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            rxTuning <= rtsc_pkg::RX_RESET;
            lockThr <= rtsc_pkg::THR_RESET;
            winLen <= rtsc_pkg::WIN_LEN_RESET;
            chanWord <= rtsc_pkg::CHAN_RESET;
        end else begin
            rxTuning <= next_rxTuning;
            lockThr <= next_lockThr;
            winLen <= next_winLen;
            chanWord <= next_chanWord;
        end
    end

    // no local copy: the analog side sees the stored bits
    // front-end fields straight from the stored bits
    assign bandpassLowBiasSel = rxTuning[rtsc_pkg::RX_BPF_LOW_BIT];
    assign bandpassMidBiasSel = rxTuning[rtsc_pkg::RX_BPF_MID_BIT];
    assign ampLowgainInAgcLow = rxTuning[rtsc_pkg::RX_AMP_LOWGAIN_LOW_BIT];
    assign ampLowgainInAgcMedium = rxTuning[rtsc_pkg::RX_AMP_LOWGAIN_MED_BIT];
    assign mixerHighgainInAgcHigh = rxTuning[rtsc_pkg::RX_MIX_HGM_HIGH_BIT];
    assign mixerHighgainInAgcMedium = rxTuning[rtsc_pkg::RX_MIX_HGM_MED_BIT];
    assign ampVaractorSel = rxTuning[rtsc_pkg::RX_VARACTOR_LO +: 2];
    assign mixerOutputCurrent = rxTuning[rtsc_pkg::RX_MIX_TAIL_LO +: 2];
    assign mixerCommonModeLevel = rxTuning[rtsc_pkg::RX_MIX_VCM_LO +: 2];
    assign mixerCoreCurrent = rxTuning[rtsc_pkg::RX_MIX_CUR_LO +: 2];

    // window width decode, combinational setting
    assign windowPeriods = winLen ? rtsc_pkg::WIN_LONG_PERIODS : rtsc_pkg::WIN_SHORT_PERIODS;

    // ----------------------------------------------------------------
    // calibration tracking
    // ----------------------------------------------------------------
    logic synthOnPrev;  // for turn-on edge
    logic calPrev;      // for calibration end edge
    logic calDone;      // calibration completed since turn-on
    logic calEnd;       // calibration just finished
    logic synthTurnOn;  // synthesizer just turned on
    logic next_calDone;
    // status lines are already on the device clock
    assign calEnd = calPrev && !calActive;
    assign synthTurnOn = synthOn && !synthOnPrev;

    // completion wins over the turn-on clear, so a short calibration is not lost
    always_comb begin
        next_calDone = calDone;
        if (synthTurnOn) begin
            next_calDone = 1'b0;
        end
        if (calEnd) begin
            next_calDone = 1'b1;
        end
    end

    // calibration registers
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            synthOnPrev <= 1'b0;
            calPrev <= 1'b0;
            calDone <= 1'b0;
        end else begin
            synthOnPrev <= synthOn;
            calPrev <= calActive;
            calDone <= next_calDone;
        end
    end

    // ----------------------------------------------------------------
    // lock detector
    // ----------------------------------------------------------------
    // the detector owns the run; only its flag leaves
    rtsc_lock_if lk ();
    assign lk.enable = synthOn;
    assign lk.refTick = refTick;
    assign lk.windowOk = windowOk;
    assign lk.threshold = lockThr;
    assign synthLocked = lk.locked;

    rtsc_lock_detect u_lock (
        .clk(clk),
        .rstSync_n(rstSync_n),
        .lk(lk)
    );

    // ----------------------------------------------------------------
    // local oscillator frequency
    // ----------------------------------------------------------------
    logic [11:0] next_loFreqMhz;

    // receive mode sits below the carrier by the intermediate frequency
    always_comb begin
        next_loFreqMhz = rtsc_pkg::CARRIER_BASE_MHZ + {2'h0, chanWord};
        if (!txMode) begin
            next_loFreqMhz = next_loFreqMhz - rtsc_pkg::RX_LO_OFFSET_MHZ;
        end
    end

    // a mode switch needs no rewrite of the channel word
    // registered so the synthesizer sees a clean word
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            // reset channel in receive mode
            loFreqMhz <= rtsc_pkg::CARRIER_BASE_MHZ + {2'h0, rtsc_pkg::CHAN_RESET} - rtsc_pkg::RX_LO_OFFSET_MHZ;
        end else begin
            loFreqMhz <= next_loFreqMhz;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [15:0] next_regRdData;
    logic next_regRdValid;

    // a read beside a write returns the old value
    // status bits are sampled live, never stored from a write
    always_comb begin
        next_regRdData = 16'h0000;
        next_regRdValid = regRdEn;
        if (regRdEn && selRx) begin
            // reserved bits read as zero
            next_regRdData = {2'h0, rxTuning};
        end else if (regRdEn && selSynth) begin
            next_regRdData = {lockThr, calDone, calActive, winLen, lk.locked, chanWord};
        end
    end

    // one-cycle read answer; unmapped addresses answer zero
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            regRdData <= 16'h0000;
            regRdValid <= 1'b0;
        end else begin
            regRdData <= next_regRdData;
            regRdValid <= next_regRdValid;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // all checks sleep through reset
    sequence seq_synth_read;
        regRdEn && selSynth ##1 regRdValid;
    endsequence

    chk_reserved_reads_zero: assert property (@(posedge clk) disable iff (!rstSync_n)
        regRdEn && selRx |=> regRdValid && regRdData[15:14] == 2'h0)
        else $error("reserved tuning bits read nonzero");
    chk_gain_select_write: assert property (@(posedge clk) disable iff (!rstSync_n)
        regWrEn && selRx |=> ampLowgainInAgcLow == $past(regWrData[11])
                             && ampLowgainInAgcMedium == $past(regWrData[10]))
        else $error("gain select not taken from write");
    chk_tuning_field_write: assert property (@(posedge clk) disable iff (!rstSync_n)
        regWrEn && selRx |=> mixerCoreCurrent == $past(regWrData[1:0])
                             && ampVaractorSel == $past(regWrData[7:6]))
        else $error("tuning field not taken from write");
    chk_lock_readback: assert property (@(posedge clk) disable iff (!rstSync_n)
        seq_synth_read |-> regRdData[10] == $past(lk.locked))
        else $error("lock flag readback mismatch");
    chk_cal_done_set: assert property (@(posedge clk) disable iff (!rstSync_n)
        calEnd |=> calDone ##1 (calDone || $past(synthTurnOn)))
        else $error("calibration done not set");
    chk_cal_done_clear: assert property (@(posedge clk) disable iff (!rstSync_n)
        synthTurnOn && !calEnd |=> !calDone)
        else $error("calibration done not cleared at turn-on");
    chk_cal_active_read: assert property (@(posedge clk) disable iff (!rstSync_n)
        seq_synth_read |-> regRdData[12] == $past(calActive))
        else $error("calibration active readback mismatch");
    chk_window_width: assert property (@(posedge clk) disable iff (!rstSync_n)
        regWrEn && selSynth |=> windowPeriods == ($past(regWrData[11]) ? 3'h4 : 3'h2))
        else $error("window width decode wrong");
    chk_lo_tracks_mode: assert property (@(posedge clk) disable iff (!rstSync_n)
        ##1 loFreqMhz == 12'h800 + {2'h0, $past(chanWord)} - ($past(txMode) ? 12'h000 : 12'h002))
        else $error("local oscillator frequency wrong");
    chk_status_write_ignored: assert property (@(posedge clk) disable iff (!rstSync_n)
        regWrEn && selSynth && regWrData[13] && !calDone && !calEnd |=> !calDone)
        else $error("write reached calibration done flag");
    // power-down forgets the run, so relock needs a fresh run
    chk_run_cleared_off: assert property (@(posedge clk) disable iff (!rstSync_n)
        !synthOn |=> lk.runCount == 10'h000 && !synthLocked)
        else $error("run kept while powered down");
    chk_threshold_write: assert property (@(posedge clk) disable iff (!rstSync_n)
        regWrEn && selSynth |=> lk.threshold == $past(regWrData[15:14]))
        else $error("lock threshold not taken");
    chk_channel_readback: assert property (@(posedge clk) disable iff (!rstSync_n)
        seq_synth_read |-> regRdData[9:0] == $past(chanWord))
        else $error("channel word readback mismatch");
    chk_lock_has_run: assert property (@(posedge clk) disable iff (!rstSync_n)
        synthLocked |-> lk.runCount != 10'h000)
        else $error("lock shown without a run");

endmodule // rtsc_regs
`default_nettype wire

// File: tb/rtsc_synth_model.sv
// rtsc_synth_model: behavioural synthesizer controller feeding the status inputs
`timescale 1ns/1ps
`default_nettype none
module rtsc_synth_model (
    // device clock
    input wire logic clk,
    // status lines toward the register bank
    output logic synthOn,
    output logic txMode,
    output logic refTick,
    output logic windowOk,
    output logic calActive
);
    // ----------------------------------------------------------------
    // idle levels at time zero
    // ----------------------------------------------------------------
    initial begin
        synthOn = 1'b0;
        txMode = 1'b0;
        refTick = 1'b0;
        windowOk = 1'b1;
        calActive = 1'b0;
    end

    // all tasks are entered just after a rising edge and leave just after one
    task automatic power(input logic on);
        synthOn = on; // level, held until changed
        @(posedge clk);
        #10;
    endtask

    task automatic mode(input logic tx);
        txMode = tx; // 1 transmit, 0 receive
        @(posedge clk);
        #10;
    endtask

    // one reference period; window result valid only with the tick
    task automatic tick(input logic ok);
        refTick = 1'b1;
        windowOk = ok;
        @(posedge clk);
        #10;
        refTick = 1'b0;
        windowOk = ~ok; // not qualified now, so show the opposite level
        @(posedge clk);
        #10;
    endtask

    // run level for a calibration
    task automatic cal(input logic run);
        calActive = run;
        @(posedge clk);
        #10;
    endtask
endmodule // rtsc_synth_model
`default_nettype wire

// File: tb/rtsc_regs_tb.sv
// rtsc_regs_tb: self-checking bench for the tuning and synthesizer register bank
`timescale 1ns/1ps
`default_nettype none
module rtsc_regs_tb;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk, reset_n, regWrEn, regRdEn, regRdValid;
    logic [7:0] regAddr;
    logic [15:0] regWrData, regRdData, rdVal;
    logic synthOn, txMode, refTick, windowOk, calActive;
    logic bpLo, bpMid, agLo, agMed, mxHi, mxMed;
    logic [1:0] varSel, mxOut, mxCm, mxCore;
    logic [2:0] windowPeriods;
    logic [11:0] loFreqMhz;
    logic synthLocked;
    logic [13:0] tune; // packed front-end outputs, register order
    int n_mismatch, tests_run;
    logic [15:0] pats [2] = '{16'h25a9, 16'h3fff}; // bit 13 set, top bits zero
    logic [9:0] chans [3] = '{10'h000, 10'h165, 10'h3ff};

    assign tune = {bpLo, bpMid, agLo, agMed, mxHi, mxMed, varSel, mxOut, mxCm, mxCore};

    rtsc_synth_model model (.clk(clk), .synthOn(synthOn), .txMode(txMode),
        .refTick(refTick), .windowOk(windowOk), .calActive(calActive));

    rtsc_regs DUT (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .synthOn(synthOn), .txMode(txMode), .refTick(refTick),
        .windowOk(windowOk), .calActive(calActive), .bandpassLowBiasSel(bpLo),
        .bandpassMidBiasSel(bpMid), .ampLowgainInAgcLow(agLo), .ampLowgainInAgcMedium(agMed),
        .mixerHighgainInAgcHigh(mxHi), .mixerHighgainInAgcMedium(mxMed),
        .ampVaractorSel(varSel), .mixerOutputCurrent(mxOut), .mixerCommonModeLevel(mxCm),
        .mixerCoreCurrent(mxCore), .windowPeriods(windowPeriods), .loFreqMhz(loFreqMhz),
        .synthLocked(synthLocked));

    // ----------------------------------------------------------------
    // clock, 100 ns period
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one write strobe then one idle cycle, so strobes never touch
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clk);
        #10;
        regWrEn = 1'b0;
        @(posedge clk);
        #10;
    endtask

    // read strobe; the answer is looked at in its one valid cycle
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk);
        #10;
        regRdEn = 1'b0;
        if (regRdValid !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t read answer missing", $time);
            give_verdict();
        end
        d = regRdData;
        @(posedge clk);
        #10;
    endtask

    function automatic logic [15:0] syn(input logic [1:0] thr, input logic done, input logic act,
                                        input logic win, input logic lk, input logic [9:0] ch);
        return {thr, done, act, win, lk, ch};
    endfunction

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("CHECK FAILED t=%0t run did not finish", $time);
        give_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        regAddr = 8'h00;
        regWrData = 16'h0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        #10;
        reset_n = 1'b1;
        repeat (3) @(posedge clk); // reset sync swallows the first two edges
        #10;

        // reset values at ports and through reads
        chk({2'h0, tune}, 16'h0a56, "tuning outputs at reset");
        chk({13'h0, windowPeriods}, 16'h0002, "window width at reset");
        chk({4'h0, loFreqMhz}, 16'h0963, "lo at reset");
        rd(8'h17, rdVal);
        chk(rdVal, 16'h0a56, "tuning reset read");
        rd(8'h18, rdVal);
        chk(rdVal, syn(2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 10'h165), "synth reset read");
        $display("test reset values done");

        // tuning write patterns; reserved bits written as zero, low bias set to 1
        foreach (pats[i]) begin
            wr(8'h17, pats[i]);
            chk({2'h0, tune}, pats[i], "tuning outputs");
            rd(8'h17, rdVal);
            chk(rdVal, pats[i], "tuning read back");
        end
        wr(8'h16, 16'h0000);
        rd(8'h17, rdVal);
        chk(rdVal, 16'h3fff, "neighbour write leaves tuning");
        rd(8'h19, rdVal);
        chk(rdVal, 16'h0000, "unmapped read");
        $display("test tuning done");

        // synth word: status bits written as one are ignored, width and channel
        wr(8'h18, 16'hbfff);
        rd(8'h18, rdVal);
        chk(rdVal, 16'h8bff, "status bits not writable");
        chk({13'h0, windowPeriods}, 16'h0004, "long window");
        wr(8'h18, 16'h4165);
        chk({13'h0, windowPeriods}, 16'h0002, "short window");
        for (int m = 0; m < 2; m++) begin
            model.mode(m[0]);
            foreach (chans[i]) begin
                wr(8'h18, {6'h10, chans[i]});
                chk({4'h0, loFreqMhz}, 16'h0800 + chans[i] - (m ? 16'h0000 : 16'h0002), "lo");
            end
        end
        model.mode(1'b0);
        $display("test synth word done");

        // lock count for every threshold code
        model.power(1'b1);
        for (int t = 0; t < 4; t++) begin
            wr(8'h18, {t[1:0], 4'h0, 10'h165});
            model.tick(1'b0);
            chk({15'h0, synthLocked}, 16'h0000, "lock cleared by failed window");
            repeat ((64 << t) - 1) model.tick(1'b1);
            chk({15'h0, synthLocked}, 16'h0000, "lock one period early");
            model.tick(1'b1);
            chk({15'h0, synthLocked}, 16'h0001, "lock at threshold");
            rd(8'h18, rdVal);
            chk(rdVal, syn(t[1:0], 1'b0, 1'b0, 1'b0, 1'b1, 10'h165), "lock flag read");
        end
        // broken run restarts the count
        wr(8'h18, 16'h0165);
        model.tick(1'b0);
        repeat (63) model.tick(1'b1);
        model.tick(1'b0);
        repeat (63) model.tick(1'b1);
        chk({15'h0, synthLocked}, 16'h0000, "run restarted");
        model.tick(1'b1);
        chk({15'h0, synthLocked}, 16'h0001, "relock after full run");
        $display("test lock done");

        // calibration flags
        model.cal(1'b1);
        rd(8'h18, rdVal);
        chk(rdVal, syn(2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 10'h165), "calibration running");
        model.cal(1'b0);
        rd(8'h18, rdVal);
        chk(rdVal, syn(2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 10'h165), "calibration done");
        wr(8'h18, 16'h0165);
        rd(8'h18, rdVal);
        chk(rdVal[13], 1'b1, "done kept over write");
        model.power(1'b0);
        model.power(1'b1);
        rd(8'h18, rdVal);
        chk(rdVal, syn(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 10'h165), "turn-on clears done and lock");
        $display("test calibration done");

        give_verdict();
    end
endmodule // rtsc_regs_tb
`default_nettype wire
